// File: design/power_seq.sv
// Low power mode sequencer for a two-subsystem wireless microcontroller
`timescale 1ns/1ps
module power_seq #(
   parameter int HIB_WAKE_CYC = power_seq_pkg::HIB_WAKE_MIN_CYC,  // Hibernate wake time
   parameter int DS_EXIT_CYC  = power_seq_pkg::DS_EXIT_CYC,       // Deep sleep exit time
   parameter int BEACON_CYC   = power_seq_pkg::BEACON_CYC,        // Beacon interval
   parameter int SKIP_MAX_CYC = power_seq_pkg::SKIP_MAX_CYC       // Skip sleep ceiling
) (
   input  wire logic                         clk_sys,
   input  wire logic                         rst,
   input  wire logic                         hib_req,        // Hibernate request pin
   input  wire logic                         app_ds_req,     // App processor shutdown req
   input  wire logic                         radio_idle,     // Radio block idle
   input  wire logic                         net_cop_idle,   // network_coprocessor idle
   input  wire logic                         gpio_wake,      // External wake pin
   input  wire logic                         mode_sel,       // 1: intermittent operation
   input  wire logic                         ap_role,        // Device acts as access point
   input  wire logic [power_seq_pkg::DTIM_W-1:0] dtim_set,   // Requested DTIM period
   input  wire logic                         dtim_load,      // Apply requested DTIM period
   input  wire logic [power_seq_pkg::CNT_W-1:0] skip_sleep, // extended_beacon_skip_policy
   input  wire logic [power_seq_pkg::CNT_W-1:0] hib_period, // Intermittent sleep length
   input  wire logic                         beacon_rx,      // Beacon received (pulse)
   input  wire logic                         data_pending,   // Beacon flags pending data
   input  wire logic                         comm_done,      // All traffic finished
   input  wire logic                         net_ready,      // Init and connect finished
   output power_seq_pkg::pwr_ctl_t           pwr_ctl,        // Clock and supply controls
   output power_seq_pkg::seq_status_t        status,         // Readable status
   output logic [power_seq_pkg::DTIM_W-1:0]  dtim_period     // DTIM period in force
);
   import power_seq_pkg::*;

   // ********************************************
   // Functions
   // ********************************************
   // Clamp a requested sleep time to the skip-policy ceiling
   function automatic logic [CNT_W-1:0] clamp_sleep(input logic [CNT_W-1:0] v);
      logic [CNT_W-1:0] lim;
      lim = CNT_W'(SKIP_MAX_CYC);
      if (v == '0) begin
         clamp_sleep = CNT_W'(BEACON_CYC);
      end else if (v > lim) begin
         clamp_sleep = lim;
      end else begin
         clamp_sleep = v;
      end
   endfunction

   // Supply and clock pattern for a given state
   function automatic pwr_ctl_t ctl_for(input pstate_t s);
      pwr_ctl_t c;
      c = '{pll_en:1'b1, xtal_en:1'b1, dcdc_en:1'b1, ldo_en:1'b1,
            app_pwr_en:1'b1, net_pwr_en:1'b1, aon_low_v:1'b0, aon_slow_clk:1'b0};
      case (s)
         ST_DEEP: begin
            c.pll_en       = 1'b0;
            c.xtal_en      = 1'b0;
            c.app_pwr_en   = 1'b0;
            c.net_pwr_en   = 1'b0;
            c.aon_low_v    = 1'b1;
            c.aon_slow_clk = 1'b1;
         end
         ST_HIBERNATE: begin
            c              = '0;
            c.aon_slow_clk = 1'b1;
         end
         default: begin
            c = c;
         end
      endcase
      ctl_for = c;
   endfunction

   // Reported power state for a sequencer state, so status moves with pwr_ctl except in ST_HIB_WAKE, which still reports REP_HIB
   function automatic rep_state_t rep_for(input pstate_t s);
      case (s)
         ST_DEEP: begin
            rep_for = REP_DEEP;
         end
         ST_HIBERNATE, ST_HIB_WAKE: begin
            rep_for = REP_HIB;
         end
         default: begin
            rep_for = REP_ACTIVE;
         end
      endcase
   endfunction

   // ********************************************
   // Input synchronisers
   // ********************************************
   typedef struct packed {
      logic hib;
      logic app;
      logic radio;
      logic cop;
      logic gpio;
      logic beacon;
      logic pend;
      logic done;
      logic ready;
   } pins_t;

   pins_t pin_raw;    // Pin levels
   pins_t sync_a;     // First stage, read only by second stage
   pins_t sync_b;     // Second stage, safe to use

   assign pin_raw = '{hib:hib_req, app:app_ds_req, radio:radio_idle, cop:net_cop_idle,
                      gpio:gpio_wake, beacon:beacon_rx, pend:data_pending,
                      done:comm_done, ready:net_ready};

   // Two-flop synchroniser
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         sync_a <= '0;
         sync_b <= '0;
      end else begin
         sync_a <= pin_raw;
         sync_b <= sync_a;
      end
   end

   // ********************************************
   // Sequencer state
   // ********************************************
   typedef struct packed {
      pstate_t           st;         // Power state
      logic [CNT_W-1:0]  cnt;        // Wake or exit delay count
      pwr_ctl_t          ctl;        // Registered supply controls
      seq_status_t       stat;       // Registered status
      logic [DTIM_W-1:0] dtim;       // DTIM period in force
      logic              beacon_d;   // Beacon level, last cycle
      logic              gpio_d;     // GPIO level, last cycle
      logic              tmr_load;   // Start sleep timer
      logic [CNT_W-1:0]  tmr_val;    // Sleep timer length
      logic              tmr_stop;   // Abandon sleep timer
   } seq_t;

   seq_t cur;        // Registered state
   seq_t next_cur;   // Next state

   logic tmr_expired;  // Sleep timer elapsed
   logic net_asleep;   // Whole network subsystem idle
   logic both_ds;      // Both subsystems ask for deep sleep
   logic beacon_rise;  // Beacon arrival
   logic gpio_rise;    // GPIO wake edge

   // Network subsystem idle only when both blocks are idle
   assign net_asleep  = sync_b.radio & sync_b.cop;
   assign both_ds     = sync_b.app & net_asleep;
   assign beacon_rise = sync_b.beacon & ~cur.beacon_d;
   assign gpio_rise   = sync_b.gpio & ~cur.gpio_d;

   // Sleep interval timer
   wake_timer #(
      .W (CNT_W)
   ) u_sleep_tmr (
      .clk_sys (clk_sys),
      .rst     (rst),
      .load    (cur.tmr_load),
      .value   (cur.tmr_val),
      .stop    (cur.tmr_stop),
      .expired (tmr_expired)
   );

   // ********************************************
   // Next-state logic
   // ********************************************
   always_comb begin
      next_cur          = cur;
      next_cur.tmr_load = 1'b0;
      next_cur.tmr_stop = 1'b0;
      next_cur.beacon_d = sync_b.beacon;
      next_cur.gpio_d   = sync_b.gpio;

      // DTIM period changes only in access point role
      if (dtim_load && ap_role && dtim_set != '0) begin
         next_cur.dtim = dtim_set;
      end

      case (cur.st)
         // Running: hibernate wins over deep sleep
         ST_ACTIVE: begin
            if (sync_b.hib) begin
               next_cur.st       = ST_HIBERNATE;
               next_cur.tmr_load = mode_sel;
               next_cur.tmr_val  = hib_period;
            end else if (both_ds) begin
               next_cur.st = ST_DS_ENTER;
            end else if (mode_sel == MODE_INTERMITTENT && sync_b.done) begin
               next_cur.st       = ST_HIBERNATE;
               next_cur.tmr_load = 1'b1;
               next_cur.tmr_val  = hib_period;
            end
         end
         // Arm the beacon timer, then drop clocks and supplies
         ST_DS_ENTER: begin
            next_cur.st            = ST_DEEP;
            next_cur.tmr_load      = 1'b1;
            next_cur.tmr_val       = clamp_sleep(skip_sleep);
            next_cur.stat.app_wake = 1'b0;
            next_cur.stat.net_wake = 1'b0;
         end
         // Asleep between beacons
         ST_DEEP: begin
            if (sync_b.hib) begin
               next_cur.st       = ST_HIBERNATE;
               next_cur.tmr_stop = 1'b1;
            end else if (tmr_expired) begin
               next_cur.st            = ST_DS_EXIT;
               next_cur.cnt           = CNT_W'(DS_EXIT_CYC);
               next_cur.stat.wake_src = WK_TIMER;
               next_cur.stat.net_wake = 1'b1;
            end else if (!both_ds) begin
               next_cur.st            = ST_DS_EXIT;
               next_cur.cnt           = CNT_W'(DS_EXIT_CYC);
               next_cur.stat.wake_src = WK_DATA;
               next_cur.tmr_stop      = 1'b1;
            end
         end
         // Clocks back within the exit bound, then check the beacon
         ST_DS_EXIT: begin
            if (cur.cnt != '0) begin
               next_cur.cnt = cur.cnt - CNT_W'(1);
            end else if (!cur.stat.net_wake) begin
               next_cur.st = ST_ACTIVE;
            end else if (beacon_rise) begin
               next_cur.stat.wake_src = WK_BEACON;
               if (sync_b.pend) begin
                  next_cur.st            = ST_ACTIVE;
                  next_cur.stat.app_wake = 1'b1;
               end else begin
                  next_cur.st = ST_DS_ENTER;
               end
            end
         end
         // Lowest power, wait for timer or GPIO
         ST_HIBERNATE: begin
            if (tmr_expired) begin
               next_cur.st            = ST_HIB_WAKE;
               next_cur.cnt           = CNT_W'(HIB_WAKE_CYC);
               next_cur.stat.wake_src = WK_TIMER;
            end else if (gpio_rise) begin
               next_cur.st            = ST_HIB_WAKE;
               next_cur.cnt           = CNT_W'(HIB_WAKE_CYC);
               next_cur.stat.wake_src = WK_GPIO;
               next_cur.tmr_stop      = 1'b1;
            end
         end
         // Regulators and clocks come back
         ST_HIB_WAKE: begin
            if (cur.cnt > CNT_W'(1)) begin
               next_cur.cnt = cur.cnt - CNT_W'(1);
            end else begin
               next_cur.st               = ST_NET_INIT;
               next_cur.stat.new_connect = 1'b1;
            end
         end
         // Coprocessor init and fresh association
         ST_NET_INIT: begin
            if (sync_b.ready) begin
               next_cur.st = ST_COMM;
            end
         end
         // Communicate, then return to hibernate
         ST_COMM: begin
            if (sync_b.done || sync_b.hib) begin
               next_cur.st               = ST_HIBERNATE;
               next_cur.stat.new_connect = 1'b0;
               next_cur.tmr_load         = 1'b1;
               next_cur.tmr_val          = hib_period;
            end
         end
         default: begin
            next_cur.st = ST_ACTIVE;
         end
      endcase

      next_cur.ctl        = ctl_for(next_cur.st);
      next_cur.stat.state = rep_for(next_cur.st);
   end

   // ********************************************
   // State register
   // ********************************************
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cur      <= '0;
         cur.st   <= ST_ACTIVE;
         cur.ctl  <= '{pll_en:1'b1, xtal_en:1'b1, dcdc_en:1'b1, ldo_en:1'b1,
                       app_pwr_en:1'b1, net_pwr_en:1'b1, aon_low_v:1'b0,
                       aon_slow_clk:1'b0};
         cur.dtim <= DTIM_RESET;
      end else begin
         cur <= next_cur;
      end
   end

   // Outputs straight from flip-flops
   assign pwr_ctl     = cur.ctl;
   assign status      = cur.stat;
   assign dtim_period = cur.dtim;
endmodule

// File: design/power_seq_pkg.sv
// Constants and types shared by the low power mode sequencer
//
// Function
// - Hibernate request goes straight to hibernate
// - Hibernate switches off every internal regulator
// - Hibernate keeps only battery logic on 32 kHz
// - Hibernate wake takes 15 ms to 250 ms
// - Deep sleep needs both subsystem shutdown requests
// - Deep sleep stops PLL and crystal oscillator
// - Deep sleep cuts subsystems, lowers always-on supply
// - Deep sleep logic runs from 32 kHz clock
// - Network sleeps only when radio and coprocessor idle
// - Deep sleep exit takes under 3 ms
// - DTIM period whole beacons, changeable only as AP
// - Skip policy sleep up to 2 s
// - Timer wakes network subsystem before beacon
// - Pending data after beacon wakes processor
// - Connected station sleeps between beacon windows
// - Intermittent mode wakes on timer or GPIO
// - Intermittent wake sets up fresh connection
// - Init coprocessor, connect, communicate, rehibernate
package power_seq_pkg;

   // ********************************************
   // Timing
   // ********************************************
   localparam int CLK_MHZ           = 200;      // System clock rate
   localparam int HIB_WAKE_MIN_US   = 15000;    // Least hibernate wake time
   localparam int HIB_WAKE_MAX_US   = 250000;   // Longest hibernate wake time
   localparam int DS_EXIT_MAX_US    = 3000;     // Longest deep sleep exit
   localparam int BEACON_US_X10     = 1024000;  // Beacon interval, tenths of us
   localparam int SKIP_MAX_US       = 2000000;  // Longest skip-policy sleep
   localparam int SKIP_REC_US       = 500000;   // Recommended skip-policy bound
   // Cycle counts derived from the times
   localparam int HIB_WAKE_MIN_CYC  = HIB_WAKE_MIN_US * CLK_MHZ;
   localparam int HIB_WAKE_MAX_CYC  = HIB_WAKE_MAX_US * CLK_MHZ;
   localparam int DS_EXIT_CYC       = DS_EXIT_MAX_US * CLK_MHZ - 1;
   localparam int BEACON_CYC        = BEACON_US_X10 / 10 * CLK_MHZ;
   localparam int SKIP_MAX_CYC      = SKIP_MAX_US * CLK_MHZ;
   localparam int CNT_W             = 32;       // Timer width
   localparam int DTIM_W            = 8;        // DTIM period field width
   localparam logic [DTIM_W-1:0] DTIM_RESET = 8'h01; // Every beacon

   // ********************************************
   // Power states, one-hot
   // ********************************************
   typedef enum logic [7:0] {
      ST_ACTIVE    = 8'h01,   // Both subsystems running
      ST_DS_ENTER  = 8'h02,   // Stopping clocks and supplies
      ST_DEEP      = 8'h04,   // deep_sleep_state
      ST_DS_EXIT   = 8'h08,   // Restoring from deep sleep
      ST_HIBERNATE = 8'h10,   // Lowest power state
      ST_HIB_WAKE  = 8'h20,   // Regulators coming back
      ST_NET_INIT  = 8'h40,   // Coprocessor init and fresh connect
      ST_COMM      = 8'h80    // Intermittent communication window
   } pstate_t;

   // Reported power state
   typedef enum logic [1:0] {
      REP_ACTIVE = 2'h0,
      REP_DEEP   = 2'h1,
      REP_HIB    = 2'h2
   } rep_state_t;

   // Last wake source
   typedef enum logic [2:0] {
      WK_NONE   = 3'h0,
      WK_TIMER  = 3'h1,
      WK_GPIO   = 3'h2,
      WK_BEACON = 3'h3,
      WK_DATA   = 3'h4
   } wake_src_t;

   // Operating mode
   typedef enum logic [0:0] {
      MODE_CONNECTED    = 1'h0,
      MODE_INTERMITTENT = 1'h1
   } op_mode_t;

   // Power and clock controls to the chip
   typedef struct packed {
      logic pll_en;        // PLL running
      logic xtal_en;       // 40 MHz crystal running
      logic dcdc_en;       // DC/DC converter on
      logic ldo_en;        // LDOs on
      logic app_pwr_en;    // Application processor power
      logic net_pwr_en;    // Network subsystem power
      logic aon_low_v;     // Always-on domain at 0.9 V
      logic aon_slow_clk;  // Always-on logic on 32 kHz clock
   } pwr_ctl_t;

   // Status shown to the application processor
   typedef struct packed {
      rep_state_t state;
      wake_src_t  wake_src;
      logic       new_connect;  // Fresh association required
      logic       app_wake;     // Processor woken for data
      logic       net_wake;     // Network woken for beacon
   } seq_status_t;

endpackage

// File: design/wake_timer.sv
// Down counter that pulses once its load value has elapsed
`timescale 1ns/1ps
module wake_timer #(
   parameter int W = 32
) (
   input  wire logic         clk_sys,
   input  wire logic         rst,
   input  wire logic         load,     // Start a new count
   input  wire logic [W-1:0] value,    // Cycles to count
   input  wire logic         stop,     // Abandon the count
   output logic              expired   // One-cycle pulse at terminal count
);
   // ********************************************
   // State
   // ********************************************
   typedef struct packed {
      logic [W-1:0] count;    // Remaining cycles
      logic         running;  // Count in progress
      logic         expired;  // Terminal pulse
   } tmr_t;

   tmr_t cur;       // Registered state
   tmr_t next_cur;  // Next state

   // Next-state logic
   always_comb begin
      next_cur         = cur;
      next_cur.expired = 1'b0;
      if (stop) begin
         next_cur.running = 1'b0;
      end else if (load) begin
         next_cur.count   = value;
         next_cur.running = 1'b1;
      end else if (cur.running) begin
         if (cur.count <= W'(1)) begin
            next_cur.running = 1'b0;
            next_cur.expired = 1'b1;
         end else begin
            next_cur.count = cur.count - W'(1);
         end
      end
   end

   // State register
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cur <= '0;
      end else begin
         cur <= next_cur;
      end
   end

   assign expired = cur.expired;
endmodule

// File: verification/power_seq_assertions.sv
// Concurrent checks on the ports of the low power mode sequencer
`timescale 1ns/1ps
module power_seq_assertions
   import power_seq_pkg::*;
(
   input wire logic                clk_sys,
   input wire logic                rst,
   input wire logic                hib_req,
   input wire logic                app_ds_req,
   input wire logic                radio_idle,
   input wire logic                net_cop_idle,
   input wire logic                gpio_wake,
   input wire logic                mode_sel,
   input wire logic                ap_role,
   input wire logic [DTIM_W-1:0]   dtim_set,
   input wire logic                dtim_load,
   input wire logic [CNT_W-1:0]    skip_sleep,
   input wire logic [CNT_W-1:0]    hib_period,
   input wire logic                beacon_rx,
   input wire logic                data_pending,
   input wire logic                comm_done,
   input wire logic                net_ready,
   input wire pwr_ctl_t            pwr_ctl,
   input wire seq_status_t         status,
   input wire logic [DTIM_W-1:0]   dtim_period
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);

   // ********************************************
   // Supplies and clocks
   // ********************************************
   hib_regs_off_a: assert property (!pwr_ctl.dcdc_en |-> pwr_ctl == 8'h01)
      else $error("regulators off but other controls still on");
   deep_clock_a: assert property (!pwr_ctl.pll_en |-> pwr_ctl.aon_slow_clk && !pwr_ctl.xtal_en)
      else $error("PLL stopped without slow clock or with crystal on");
   deep_supply_a: assert property (pwr_ctl.aon_low_v |->
      !pwr_ctl.app_pwr_en && !pwr_ctl.net_pwr_en && !pwr_ctl.pll_en)
      else $error("always-on supply lowered with subsystems powered");
   deep_both_a: assert property ($fell(pwr_ctl.pll_en) && pwr_ctl.dcdc_en |->
      $past(app_ds_req, 4) && $past(radio_idle, 4) && $past(net_cop_idle, 4))
      else $error("deep sleep entered without all three requests");
   hib_entry_a: assert property ($rose(hib_req) && pwr_ctl == 8'hFC && status.state == REP_ACTIVE
      |-> ##[1:4] pwr_ctl == 8'h01)
      else $error("hibernate request did not reach hibernate directly");

   // ********************************************
   // Wake-ups and status
   // ********************************************
   dtim_guard_a: assert property ($changed(dtim_period) |-> dtim_period != 8'h00 &&
      $past(ap_role, 1) && $past(dtim_load, 1))
      else $error("DTIM period changed without an access point write");
   beacon_wake_a: assert property ($rose(status.net_wake) |->
      status.wake_src == WK_TIMER && pwr_ctl.pll_en)
      else $error("network wake without timer source or clocks");
   fresh_conn_a: assert property ($rose(status.new_connect) |->
      status.wake_src inside {WK_TIMER, WK_GPIO} && pwr_ctl.dcdc_en)
      else $error("fresh connection without timer or pin wake");
   data_wake_a: assert property ($rose(status.app_wake) |->
      status.state == REP_ACTIVE && pwr_ctl == 8'hFC)
      else $error("processor woken for data while not fully powered");
endmodule

// File: verification/ap_beacon_model.sv
// Access point model sending beacons and flagging data on DTIM beacons
`timescale 1ns/1ps
module ap_beacon_model #(
   parameter int PERIOD = 200,  // Beacon interval in cycles
   parameter int DTIM   = 2     // Beacons per DTIM
) (
   input  wire logic clk_sys,
   input  wire logic rst,
   output logic      beacon_rx,
   output logic      data_pending
);
   int cnt;  // Cycle within the beacon interval
   int idx;  // Beacon number
   // Beacon pulse held four cycles; pending data only on DTIM beacons
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cnt          <= 0;
         idx          <= 0;
         beacon_rx    <= 1'b0;
         data_pending <= 1'b0;
      end else begin
         cnt       <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
         idx       <= (cnt == PERIOD - 1) ? idx + 1 : idx;
         beacon_rx <= (cnt < 4);
         // Outside a beacon the flag is meaningless, so it toggles
         data_pending <= (cnt < 4) ? ((idx % DTIM) == DTIM - 1) : ~data_pending;
      end
   end
endmodule

// File: verification/tb.sv
// Self-checking bench for the low power mode sequencer
`timescale 1ns/1ps
module tb;
   import power_seq_pkg::*;
   // ********************************************
   // Set-up
   // ********************************************
   localparam int HWC = 20;    // Shortened hibernate wake
   localparam int BCN = 200;   // Shortened beacon interval
   localparam int SKM = 1000;  // Shortened skip ceiling
   logic              clk_sys = 1'b0, rst = 1'b1, hib_req = 1'b0, gpio_wake = 1'b0;
   logic              app_ds_req = 1'b0, radio_idle = 1'b0, net_cop_idle = 1'b0;
   logic              mode_sel = 1'b0, ap_role = 1'b0, dtim_load = 1'b0;
   logic              net_ready = 1'b0, comm_done = 1'b0, bcn_q = 1'b0, last_pend = 1'b0;
   logic [DTIM_W-1:0] dtim_set = 8'h00, dtim_period, v;
   logic [CNT_W-1:0]  skip_sleep = 32'h00000000, hib_period = 32'h00000000;
   logic [31:0]       seed = 32'h000135C9, r;
   logic              beacon_rx, data_pending;
   pwr_ctl_t          pwr_ctl;
   seq_status_t       status;
   int                failures = 0, checked = 0, cycles = 0, n;

   always #2.5 clk_sys = ~clk_sys;

   power_seq #(.HIB_WAKE_CYC(HWC), .DS_EXIT_CYC(5), .BEACON_CYC(BCN), .SKIP_MAX_CYC(SKM))
   power_seq_inst (.clk_sys, .rst, .hib_req, .app_ds_req, .radio_idle, .net_cop_idle,
      .gpio_wake, .mode_sel, .ap_role, .dtim_set, .dtim_load, .skip_sleep, .hib_period,
      .beacon_rx, .data_pending, .comm_done, .net_ready, .pwr_ctl, .status, .dtim_period);
   ap_beacon_model #(.PERIOD(BCN), .DTIM(2)) ap_beacon_model_inst (.clk_sys, .rst,
      .beacon_rx, .data_pending);

   // Beacon monitor and hang guard
   always @(posedge clk_sys) begin
      cycles++;
      if (beacon_rx && !bcn_q) last_pend <= data_pending;
      bcn_q <= beacon_rx;
      if (cycles == 20000) begin
         failures++;
         wrap_up();
      end
   end

   // ********************************************
   // Tasks
   // ********************************************
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic tick(input int k);
      repeat (k) @(posedge clk_sys);
      #1;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   task automatic wrap_up();
      if (failures == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   // ********************************************
   // Scenarios
   // ********************************************
   initial begin
      tick(4);
      rst = 1'b0;
      tick(3);
      chk("reset controls", 8'hFC, pwr_ctl);
      chk("reset status", 8'h00, status);
      chk("reset dtim", 8'h01, dtim_period);
      // DTIM writes: refused as station, taken as access point, zero ignored
      r = rnd();
      dtim_set = {2'h0, r[5:0]} + 8'h02;
      v = dtim_set;
      dtim_load = 1'b1;
      tick(1);
      dtim_load = 1'b0;
      tick(5);
      chk("dtim station", 8'h01, dtim_period);
      ap_role = 1'b1;
      dtim_load = 1'b1;
      tick(1);
      dtim_load = 1'b0;
      tick(5);
      chk("dtim ap", v, dtim_period);
      dtim_set = 8'h00;
      dtim_load = 1'b1;
      tick(1);
      dtim_load = 1'b0;
      tick(5);
      chk("dtim zero", v, dtim_period);
      ap_role = 1'b0;
      // Every partial set of shutdown requests is refused
      for (int i = 0; i < 7; i++) begin
         {app_ds_req, radio_idle, net_cop_idle} = i[2:0];
         tick(10);
         chk("partial request", 8'hFC, pwr_ctl);
      end
      // Deep sleep entry with an over-long skip time
      skip_sleep = 32'hFFFFFFFF;
      {app_ds_req, radio_idle, net_cop_idle} = 3'h7;
      n = 0;
      while (status.state != REP_DEEP && n < 20) begin tick(1); n++; end
      chk("deep controls", 8'h33, pwr_ctl);
      n = 0;
      while (!status.net_wake && n < 2000) begin tick(1); n++; end
      chk("skip clamp", 32'h1, {31'h0, n >= SKM - 8 && n <= SKM + 8});
      chk("net wake source", WK_TIMER, status.wake_src);
      // Shorter sleep shifts the beacon phase: one empty beacon, then a DTIM one
      skip_sleep = 32'h00000384;
      n = 0;
      while (!status.app_wake && n < 6000) begin tick(1); n++; end
      chk("pending beacon", 32'h1, {31'h0, last_pend && n > 900});
      chk("data wake state", REP_ACTIVE, status.state);
      // Withdrawing the requests brings the device back awake after a brief deep sleep
      {app_ds_req, radio_idle, net_cop_idle} = 3'h0;
      tick(10);
      n = 0;
      while (!(status.state == REP_ACTIVE && pwr_ctl == 8'hFC) && n < 50) begin tick(1); n++; end
      tick(10);
      chk("awake after release", 8'hFC, pwr_ctl);
      // Intermittent cycle: hibernate, pin wake, connect, timer wake
      mode_sel = 1'b1;
      r = rnd();
      hib_period = 32'h0000012C + {24'h000000, r[7:0]};
      hib_req = 1'b1;
      n = 0;
      while (pwr_ctl != 8'h01 && n < 10) begin tick(1); n++; end
      hib_req = 1'b0;
      chk("hibernate state", REP_HIB, status.state);
      tick(50);
      chk("hibernate held", 8'h01, pwr_ctl);
      gpio_wake = 1'b1;
      n = 0;
      while (!status.new_connect && n < 100) begin tick(1); n++; end
      chk("hibernate wake time", 32'h1, {31'h0, n >= HWC && n <= HWC + 8});
      chk("pin wake source", WK_GPIO, status.wake_src);
      gpio_wake = 1'b0;
      net_ready = 1'b1;
      tick(6);
      comm_done = 1'b1;
      n = 0;
      while (pwr_ctl != 8'h01 && n < 20) begin tick(1); n++; end
      chk("back to hibernate", REP_HIB, status.state);
      net_ready = 1'b0;
      comm_done = 1'b0;
      n = 0;
      while (status.wake_src != WK_TIMER && n < 1000) begin tick(1); n++; end
      chk("timer wake", 32'h1, {31'h0, n >= hib_period - 4 && n <= hib_period + HWC + 8});
      tick(HWC + 4);
      chk("fresh connect", 32'h1, {31'h0, status.new_connect});
      // Reset in mid-run restores the reset values
      rst = 1'b1;
      tick(2);
      rst = 1'b0;
      tick(1);
      chk("rerun controls", 8'hFC, pwr_ctl);
      chk("rerun dtim", 8'h01, dtim_period);
      wrap_up();
   end
endmodule

bind power_seq power_seq_assertions power_seq_assertions_inst (.*);
